//--- common/clk_ctrl_regs.svh
// register offsets, reset values and start-up counts of the clock start-up controller
`ifndef CLK_CTRL_REGS_SVH
`define CLK_CTRL_REGS_SVH

`define OFF_CTRL      8'h00
`define OFF_PRESCALE  8'h04
`define OFF_STATUS    8'h08
`define OFF_TIMING    8'h0C

`define CTRL_MODE_LSB 0
`define CTRL_GO_BIT   3
`define PSC_MAX       4'h8
`define PSC_DIV8      4'h3
`define PSC_DIV1      4'h0

// shipped fuse state: calibrated rc, longest start-up, divide-by-eight programmed
`define DEF_SOURCE_SEL  4'h2
`define DEF_STARTUP_SEL 2'h2
`define DEF_DIV8_FUSE   1'b0

`define TOUT_NONE    16'h0000
`define TOUT_SHORT   16'h0200
`define TOUT_LONG    16'h2000
`define START_EXT    16'h0006
`define START_RC     16'h0006
`define START_LF     16'h8000
`define START_LP_S   16'h0102
`define START_LP_M   16'h0400
`define START_LP_L   16'h4000

`endif

//--- common/clk_ctrl_pkg.sv
// types shared by the clock start-up controller
package clk_ctrl_pkg;
  typedef enum logic [2:0] {
    SRC_EXT     = 3'b000,
    SRC_RC_CAL  = 3'b001,
    SRC_RC_128K = 3'b010,
    SRC_LF_XTAL = 3'b011,
    SRC_FS_XTAL = 3'b100,
    SRC_LP_XTAL = 3'b101
  } source_type;

  typedef enum logic [2:0] {
    ST_HOLD    = 3'b000,
    ST_TIMEOUT = 3'b001,
    ST_START   = 3'b010,
    ST_RUN     = 3'b011,
    ST_SLEEP   = 3'b100,
    ST_WAKE    = 3'b101
  } phase_type;

  typedef enum logic [2:0] {
    SL_IDLE     = 3'b000,
    SL_CONV     = 3'b001,
    SL_PDOWN    = 3'b010,
    SL_PSAVE    = 3'b011,
    SL_STANDBY  = 3'b110,
    SL_XSTANDBY = 3'b111
  } sleep_type;
endpackage

//--- common/osc_count_if.sv
// link between the sequencer and its cycle counter
`timescale 1ns/10ps
`default_nettype none
interface osc_count_if #(parameter int WIDTH = 16);
  logic             load;
  logic [WIDTH-1:0] length;
  logic             tick;
  logic             done;
  modport ctrl (output load, output length, output tick, input done);
  modport cnt  (input load, input length, input tick, output done);
endinterface
`default_nettype wire

//--- verilog/startup_counter.sv
// down-counter of oscillator or watchdog cycles for the reset sequencer
`timescale 1ns/10ps
`default_nettype none
module startup_counter #(
  parameter int WIDTH = 16
) (
  input wire logic   clk_sys, // system clock
  input wire logic   rst,     // async reset, high
  osc_count_if.cnt   cif      // load, length, tick, done
);
  logic [WIDTH-1:0] remaining;
  logic             armed;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      remaining <= '0;
      armed     <= 1'b0;
    end
    else if (cif.load)
    begin
      remaining <= cif.length;
      armed     <= 1'b1;
    end
    else if (armed && cif.tick && remaining != '0)
      remaining <= remaining - 1'b1;
  end

  // done must not look at load: load is decoded from done, a zero-delay loop otherwise
  assign cif.done = armed && remaining == '0;
endmodule
`default_nettype wire

//--- verilog/clock_source_startup_ctrl.sv
// clock source decode, reset time-out sequencing and clock domain gating
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - source codes 1111-1000 low power, 0111-0110 full swing, 0101-0100 low freq
// - 0011 128kHz rc, 0010 calibrated rc, 0000 external, 0001 reserved
// - fuse reads one unprogrammed, zero programmed; decode uses that polarity
// - shipped default: calibrated rc, divide by eight, start-up 10, long time-out
// - internal reset stays asserted a time-out after other resets release
// - time-out counted in watchdog cycles, length from both fuse fields
// - time-out is 0, 512 or 8192 watchdog cycles
// - count of oscillator cycles holds reset, then execution starts
// - start-up count from 6 (external clock) to 32K (low freq crystal)
// - reset start uses time-out plus start-up; wake from power-down or power-save uses start-up only, other sleep modes wake at once
// - with brown-out detection reset holds while supply is low
// - core, peripheral, flash and converter clocks run at the prescaler output rate
// - core clock halted means the core does nothing
// - peripheral clock drives timers; two-wire address match works in all sleep
// - flash interface clock runs together with the core clock
// - async timer domain keeps running from its own clock in sleep, except in power-down and standby
// - converter domain runs while core and peripheral clocks are halted
// - level wake needs level held to start-up end, else no interrupt
// - low power crystal wake count is 258, 1K or 16K cycles
module clock_source_startup_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int TOUT_LONG_CYC = `TOUT_LONG
) (
  input  wire logic        clk_sys,               // 200 MHz system clock
  input  wire logic        rst,                   // async reset, high
  input  wire logic        psel,                  // apb select
  input  wire logic        penable,               // apb access phase
  input  wire logic        pwrite,                // apb write
  input  wire logic [7:0]  paddr,                 // apb byte address
  input  wire logic [31:0] pwdata,                // apb write data
  output logic      [31:0] prdata,                // apb read data
  output logic             pready,                // apb ready
  output logic             pslverr,               // apb error, unmapped
  input  wire logic        reset_source_active,   // any other reset asserted
  input  wire logic        brownout_detector_en,  // brown-out detection in use
  input  wire logic        supply_low,            // brown-out: supply too low
  input  wire logic [3:0]  clock_source_select,   // source fuse field
  input  wire logic [1:0]  startup_time_select,   // start-up fuse field
  input  wire logic        divide_by_eight_fuse,  // 0 = programmed
  input  wire logic        wdt_osc_tick,          // one watchdog osc cycle
  input  wire logic        osc_tick,              // one selected osc cycle
  input  wire logic        wake_event,            // wake request in sleep
  input  wire logic        level_irq,             // level interrupt line
  output logic             internal_reset,        // device held in reset
  output logic             core_clock_en,         // core clock gate
  output logic             peripheral_clock_en,   // peripheral clock gate
  output logic             flash_if_clock_en,     // flash clock gate
  output logic             async_timer_clock_en,  // async timer domain on
  output logic             converter_clock_en,    // converter clock gate
  output logic             twi_addr_match_en,     // address match alive
  output logic             wake_irq,              // level interrupt on wake
  output source_type       selected_source        // decoded source
);
  localparam int TOUT_SHORT_CYC = `TOUT_SHORT;

  ////////////////////////////////////////////////////////////////////////////
  // decoding, raw fuse bit values used as read
  function automatic source_type decode_source(input logic [3:0] sel);
    if (sel[3])
      return SRC_LP_XTAL;
    else if (sel[3:1] == 3'b011)
      return SRC_FS_XTAL;
    else if (sel[3:1] == 3'b010)
      return SRC_LF_XTAL;
    else if (sel == 4'h3)
      return SRC_RC_128K;
    else if (sel == 4'h0)
      return SRC_EXT;
    else
      // reserved 0001 falls back to the calibrated rc
      return SRC_RC_CAL;
  endfunction

  function automatic logic [15:0] timeout_len(input logic [3:0] sel, input logic [1:0] stime);
    logic [2:0] code;
    code = {sel[0], stime};
    if (sel[3:2] != 2'b00 || sel[3:1] == 3'b011)
    begin
      unique case (code)
        3'b000, 3'b011, 3'b110: return 16'(TOUT_SHORT_CYC);
        3'b001, 3'b100, 3'b111: return 16'(TOUT_LONG_CYC);
        default:                return `TOUT_NONE;
      endcase
    end
    else
    begin
      unique case (stime)
        2'b00:   return `TOUT_NONE;
        2'b01:   return 16'(TOUT_SHORT_CYC);
        default: return 16'(TOUT_LONG_CYC);
      endcase
    end
  endfunction

  function automatic logic [15:0] startup_len(input logic [3:0] sel, input logic [1:0] stime);
    source_type src;
    src = decode_source(sel);
    unique case (src)
      SRC_EXT:     return `START_EXT;
      SRC_LF_XTAL: return `START_LF;
      SRC_RC_CAL,
      SRC_RC_128K: return `START_RC;
      default:
      begin
        if (!sel[0] && !stime[1])
          return `START_LP_S;
        else if (!sel[0] || stime == 2'b00)
          return `START_LP_M;
        else
          return `START_LP_L;
      end
    endcase
  endfunction

  function automatic logic [3:0] clamp_psc(input logic [3:0] v);
    return (v > `PSC_MAX) ? `PSC_MAX : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // fuse capture and sequencer
  logic [3:0]  fuse_sel;
  logic [1:0]  fuse_stime;
  logic        fuse_div8;
  logic [3:0]  psc_sel;
  logic [7:0]  psc_cnt;
  logic        sys_tick;
  logic [2:0]  mode_reg;
  sleep_type   sleep_mode;
  logic        sleep_go;
  logic        hold_req;
  logic [15:0] tout_len;
  logic [15:0] start_len;
  phase_type   phase;
  phase_type   next_phase;
  logic        deep_sleep;

  osc_count_if #(.WIDTH(16)) cif ();

  startup_counter #(.WIDTH(16)) u_counter (
    .clk_sys (clk_sys),
    .rst     (rst),
    .cif     (cif)
  );

  assign hold_req  = reset_source_active || (brownout_detector_en && supply_low);
  assign tout_len  = timeout_len(fuse_sel, fuse_stime);
  assign start_len = startup_len(fuse_sel, fuse_stime);
  assign selected_source = decode_source(fuse_sel);
  assign deep_sleep = sleep_mode == SL_PDOWN || sleep_mode == SL_PSAVE;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      fuse_sel  <= `DEF_SOURCE_SEL;
      fuse_stime <= `DEF_STARTUP_SEL;
      fuse_div8 <= `DEF_DIV8_FUSE;
    end
    else if (phase == ST_HOLD)
    begin
      fuse_sel  <= clock_source_select;
      fuse_stime <= startup_time_select;
      fuse_div8 <= divide_by_eight_fuse;
    end
  end

  always_comb
  begin
    next_phase = phase;
    unique case (phase)
      ST_HOLD:    if (!hold_req) next_phase = ST_TIMEOUT;
      ST_TIMEOUT: if (cif.done) next_phase = ST_START;
      ST_START:   if (cif.done) next_phase = ST_RUN;
      ST_RUN:     if (sleep_go) next_phase = ST_SLEEP;
      ST_SLEEP:   if (wake_event) next_phase = deep_sleep ? ST_WAKE : ST_RUN;
      ST_WAKE:    if (cif.done) next_phase = ST_RUN;
      default:    next_phase = ST_HOLD;
    endcase
    if (hold_req)
      next_phase = ST_HOLD;
  end

  assign cif.load   = next_phase != phase &&
                      (next_phase == ST_TIMEOUT || next_phase == ST_START || next_phase == ST_WAKE);
  assign cif.length = (next_phase == ST_TIMEOUT) ? tout_len : start_len;
  assign cif.tick   = (phase == ST_TIMEOUT) ? wdt_osc_tick : osc_tick;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase          <= ST_HOLD;
      internal_reset <= 1'b1;
    end
    else
    begin
      phase          <= next_phase;
      internal_reset <= next_phase == ST_HOLD || next_phase == ST_TIMEOUT || next_phase == ST_START;
    end
  end

  // interrupt only if level still held
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wake_irq <= 1'b0;
    else
      wake_irq <= level_irq && ((phase == ST_WAKE && cif.done && !hold_req) ||
                                (phase == ST_SLEEP && wake_event && !deep_sleep && !hold_req));
  end

  ////////////////////////////////////////////////////////////////////////////
  // prescaler and clock gates
  // every gate except the async timer gate rides on one tick
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      psc_cnt <= 8'h00;
    else
      psc_cnt <= psc_cnt + 8'h01;
  end

  assign sys_tick = (psc_cnt & 8'((9'h001 << psc_sel) - 9'h001)) == 8'h00;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      core_clock_en        <= 1'b0;
      peripheral_clock_en  <= 1'b0;
      converter_clock_en   <= 1'b0;
      async_timer_clock_en <= 1'b0;
    end
    else
    begin
      core_clock_en       <= !sys_tick_next_hold() && next_phase == ST_RUN && next_tick();
      peripheral_clock_en <= next_tick() && (next_phase == ST_RUN ||
                             (next_phase == ST_SLEEP && sleep_mode == SL_IDLE));
      converter_clock_en  <= next_tick() && (next_phase == ST_RUN || (next_phase == ST_SLEEP &&
                             (sleep_mode == SL_IDLE || sleep_mode == SL_CONV)));
      async_timer_clock_en <= !internal_reset && !(next_phase == ST_SLEEP &&
                              (sleep_mode == SL_PDOWN || sleep_mode == SL_STANDBY));
    end
  end

  function automatic logic next_tick();
    logic [7:0] n;
    n = psc_cnt + 8'h01;
    return (n & 8'((9'h001 << psc_sel) - 9'h001)) == 8'h00;
  endfunction

  function automatic logic sys_tick_next_hold();
    return hold_req;
  endfunction

  assign flash_if_clock_en = core_clock_en;
  // address match is asynchronous to every gate
  assign twi_addr_match_en = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states, read data captured in setup
  logic       setup_ph;
  logic       wr_en;
  logic       hit;
  logic [31:0] rd_mux;

  assign setup_ph = psel && !penable;
  assign wr_en    = psel && penable && pwrite;
  assign pready   = 1'b1;
  assign hit      = paddr == `OFF_CTRL || paddr == `OFF_PRESCALE ||
                    paddr == `OFF_STATUS || paddr == `OFF_TIMING;

  always_comb
  begin
    rd_mux = 32'h00000000;
    unique case (paddr)
      `OFF_CTRL:     rd_mux = {29'h0, mode_reg};
      `OFF_PRESCALE: rd_mux = {28'h0, psc_sel};
      `OFF_STATUS:   rd_mux = {19'h0, fuse_div8, fuse_stime, fuse_sel, selected_source, phase};
      `OFF_TIMING:   rd_mux = {tout_len, start_len};
      default:       rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata  <= pwrite ? 32'h00000000 : rd_mux;
      pslverr <= !hit;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mode_reg <= 3'b000;
      sleep_go <= 1'b0;
    end
    else
    begin
      sleep_go <= wr_en && paddr == `OFF_CTRL && pwdata[`CTRL_GO_BIT];
      if (wr_en && paddr == `OFF_CTRL)
        mode_reg <= pwdata[`CTRL_MODE_LSB +: 3];
    end
  end

  // codes 100 and 101 are unused and behave as idle
  always_comb
  begin
    unique case (mode_reg)
      3'b001:  sleep_mode = SL_CONV;
      3'b010:  sleep_mode = SL_PDOWN;
      3'b011:  sleep_mode = SL_PSAVE;
      3'b110:  sleep_mode = SL_STANDBY;
      3'b111:  sleep_mode = SL_XSTANDBY;
      default: sleep_mode = SL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      psc_sel <= `PSC_DIV8;
    else if (phase == ST_HOLD)
      psc_sel <= fuse_div8 ? `PSC_DIV1 : `PSC_DIV8;
    else if (wr_en && paddr == `OFF_PRESCALE)
      psc_sel <= clamp_psc(pwdata[3:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_start_end;
    phase == ST_START && cif.done && !hold_req;
  endsequence
  sequence s_released;
    !internal_reset && phase == ST_RUN;
  endsequence

  a_lp_decode: assert property (fuse_sel[3] |-> selected_source == SRC_LP_XTAL)
    else $error("low power crystal code decoded wrongly");
  a_ext_decode: assert property (fuse_sel == 4'h0 |-> selected_source == SRC_EXT)
    else $error("external clock code decoded wrongly");
  a_hold_reset: assert property (hold_req |=> internal_reset && phase == ST_HOLD)
    else $error("reset released while a source holds it");
  a_tout_values: assert property (tout_len == 16'h0000 || tout_len == 16'(TOUT_SHORT_CYC)
                                  || tout_len == 16'(TOUT_LONG_CYC))
    else $error("illegal time-out length");
  a_start_release: assert property (s_start_end |=> s_released)
    else $error("reset not released at end of start-up");
  a_wake_no_tout: assert property (phase == ST_WAKE |-> $past(phase) == ST_SLEEP || $past(phase) == ST_WAKE)
    else $error("wake entered from a path other than sleep");
  a_core_gated: assert property (phase != ST_RUN |-> !core_clock_en)
    else $error("core clock running outside run phase");
  a_flash_core: assert property (flash_if_clock_en == core_clock_en)
    else $error("flash clock differs from core clock");
  a_conv_noise: assert property (phase == ST_SLEEP && sleep_mode == SL_CONV && !hold_req
                                 ##1 phase == ST_SLEEP |-> converter_clock_en == sys_tick && !peripheral_clock_en)
    else $error("converter clock wrong in noise reduction");
  a_level_lost: assert property (phase == ST_WAKE && cif.done && !level_irq |=> !wake_irq)
    else $error("interrupt raised without held level");
  a_fuse_frozen: assert property (phase != ST_HOLD && $past(phase) != ST_HOLD |-> $stable(fuse_sel))
    else $error("fuse sample changed while running");
endmodule
`default_nettype wire

//--- sim/osc_source_model.sv
// oscillator and watchdog oscillator tick source facing the start-up controller
`timescale 1ns/10ps
`default_nettype none
module osc_source_model #(
  parameter int WDT_DIV = 4 // system cycles per watchdog cycle
) (
  input  wire logic clk_sys,      // system clock
  input  wire logic rst,          // async reset, high
  input  wire logic osc_run,      // oscillator powered
  input  wire logic osc_slow,     // one tick every other cycle
  output logic      wdt_osc_tick, // watchdog osc cycle
  output logic      osc_tick      // selected osc cycle
);
  int   wdt_cnt;
  logic phase;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wdt_cnt <= 0;
      wdt_osc_tick <= 1'b0;
    end
    else
    begin
      wdt_cnt <= (wdt_cnt == WDT_DIV - 1) ? 0 : wdt_cnt + 1;
      wdt_osc_tick <= (wdt_cnt == WDT_DIV - 1);
    end
  end
  // osc ticks only while powered
  // stopped oscillator stands still, so a sleeping count cannot advance
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      phase <= 1'b0;
      osc_tick <= 1'b0;
    end
    else
    begin
      phase <= ~phase;
      osc_tick <= osc_run & (~osc_slow | phase);
    end
  end
endmodule
`default_nettype wire

//--- sim/clock_source_startup_ctrl_tb.sv
// self-checking bench for the clock start-up controller
`timescale 1ns/10ps
`default_nettype none
`include "clk_ctrl_regs.svh"
module clock_source_startup_ctrl_tb
  import clk_ctrl_pkg::*;
();
  localparam int LONG = 16;
  localparam int WDT_DIV = 4;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic        reset_source_active = 1'b1, brownout_detector_en = 1'b0, supply_low = 1'b0;
  logic [3:0]  clock_source_select = 4'h2;
  logic [1:0]  startup_time_select = 2'h2;
  logic        divide_by_eight_fuse = 1'b0, wdt_osc_tick, osc_tick, osc_run = 1'b1, osc_slow = 1'b0;
  logic        wake_event = 1'b0, level_irq = 1'b0, internal_reset, core_clock_en, peripheral_clock_en;
  logic        flash_if_clock_en, async_timer_clock_en, converter_clock_en, twi_addr_match_en, wake_irq;
  source_type  selected_source;
  int          n_mismatch = 0, checks_done = 0;

  always #2.5 clk_sys = ~clk_sys;

  clock_source_startup_ctrl #(.TOUT_LONG_CYC(LONG)) clock_source_startup_ctrl_inst (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .reset_source_active,
    .brownout_detector_en, .supply_low, .clock_source_select, .startup_time_select, .divide_by_eight_fuse,
    .wdt_osc_tick, .osc_tick, .wake_event, .level_irq, .internal_reset, .core_clock_en, .peripheral_clock_en,
    .flash_if_clock_en, .async_timer_clock_en, .converter_clock_en, .twi_addr_match_en, .wake_irq,
    .selected_source);
  osc_source_model #(.WDT_DIV(WDT_DIV)) osc_source_model_inst (.clk_sys, .rst, .osc_run, .osc_slow,
    .wdt_osc_tick, .osc_tick);

  //////////////////////////////////////////////////////////////////////////////
  function automatic source_type exp_src(input logic [3:0] s);
    if (s[3]) return SRC_LP_XTAL;
    if (s[2:1] == 2'b11) return SRC_FS_XTAL;
    if (s[2:1] == 2'b10) return SRC_LF_XTAL;
    if (s == 4'h3) return SRC_RC_128K;
    if (s == 4'h0) return SRC_EXT;
    return SRC_RC_CAL;
  endfunction
  function automatic int exp_tout(input logic [3:0] s, input logic [1:0] u);
    int k;
    k = {s[0], u};
    if (s[3:2] != 2'b00) return (k % 3 == 0) ? 512 : (k % 3 == 1) ? LONG : 0;
    return (u == 2'b00) ? 0 : (u == 2'b01) ? 512 : LONG;
  endfunction
  function automatic int exp_start(input logic [3:0] s, input logic [1:0] u);
    int k;
    k = {s[0], u};
    if (s[3] || s[2:1] == 2'b11) return (k < 2) ? 258 : (k < 5) ? 1024 : 16384;
    return (s[2:1] == 2'b10) ? 32768 : 6;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic guard(input int n, input int lim);
    if (n >= lim)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                          output logic er);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    guard(n, 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic count_pulses(input int w, output int c, output int p, output int v, output int f);
    c = 0;
    p = 0;
    v = 0;
    f = 0;
    repeat (w)
    begin
      @(negedge clk_sys);
      c += (core_clock_en === 1'b1);
      p += (peripheral_clock_en === 1'b1);
      v += (converter_clock_en === 1'b1);
      f += (flash_if_clock_en !== core_clock_en);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic run_start(input logic [3:0] s, input logic [1:0] u, input logic d, input logic brn,
                           input logic go);
    logic [31:0] rd;
    logic        er;
    int          n, lo;
    @(posedge clk_sys);
    reset_source_active <= 1'b1;
    clock_source_select <= s;
    startup_time_select <= u;
    divide_by_eight_fuse <= d;
    brownout_detector_en <= brn;
    supply_low <= brn;
    repeat (3) @(posedge clk_sys);
    check("held", internal_reset, 1'b1);
    check("source", 32'(selected_source), 32'(exp_src(s)));
    apb_xfer(1'b0, `OFF_PRESCALE, 32'h0, rd, er);
    check("psc_load", rd, d ? 32'h0 : 32'h3);
    apb_xfer(1'b0, `OFF_STATUS, 32'h0, rd, er);
    check("status", rd[12:0], {d, u, s, exp_src(s), 3'h0});
    apb_xfer(1'b0, `OFF_TIMING, 32'h0, rd, er);
    check("timing", rd, {16'(exp_tout(s, u)), 16'(exp_start(s, u))});
    if (go)
    begin
      reset_source_active <= 1'b0;
      if (brn)
      begin
        repeat (100) @(posedge clk_sys);
        check("brownout_hold", internal_reset, 1'b1);
        supply_low <= 1'b0;
      end
      n = 0;
      while (internal_reset !== 1'b0 && n < 40000)
      begin
        @(posedge clk_sys);
        n++;
      end
      guard(n, 40000);
      lo = WDT_DIV * exp_tout(s, u) + exp_start(s, u);
      check("startup_len", 32'(n >= lo - 4 && n <= lo + 12), 32'h1);
    end
  endtask
  task automatic sleep_wake(input logic [2:0] m, input logic hold, input logic slow, input int lo, input int hi,
                            input logic exp_async);
    logic [31:0] rd;
    logic        er;
    int          c, p, v, f, n, irq, rs;
    apb_xfer(1'b1, `OFF_CTRL, 32'(m) | (32'h1 << `CTRL_GO_BIT), rd, er);
    repeat (8) @(posedge clk_sys);
    osc_run <= ~m[1];
    osc_slow <= slow;
    count_pulses(64, c, p, v, f);
    check("core_halt", c, 0);
    check("per_halt", p, 0);
    check("conv_run", 32'(v > 0), 32'(m == SL_CONV));
    check("twi_alive", twi_addr_match_en, 1'b1);
    check("async_run", async_timer_clock_en, exp_async);
    @(posedge clk_sys);
    level_irq <= 1'b1;
    wake_event <= 1'b1;
    osc_run <= 1'b1;
    @(posedge clk_sys);
    wake_event <= 1'b0;
    level_irq <= hold;
    n = 0;
    irq = 0;
    rs = 0;
    while (core_clock_en !== 1'b1 && n < 1000)
    begin
      @(negedge clk_sys);
      n++;
      irq += (wake_irq === 1'b1);
      rs += (internal_reset !== 1'b0);
    end
    guard(n, 1000);
    repeat (20)
    begin
      @(negedge clk_sys);
      irq += (wake_irq === 1'b1);
    end
    @(posedge clk_sys);
    level_irq <= 1'b0;
    osc_slow <= 1'b0;
    check("wake_len", 32'(n >= lo && n <= hi), 32'h1);
    check("wake_no_rst", rs, 0);
    check("wake_irq", irq, 32'(hold));
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [3:0]  ts [7] = '{4'h0, 4'h3, 4'h6, 4'h4, 4'hB, 4'h9, 4'h2};
    logic [1:0]  tu [7] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h2};
    logic [31:0] rd;
    logic        er;
    int          c, p, v, f, psc, per;
    void'($urandom(36));
    repeat (5) @(posedge clk_sys);
    check("rst_hold", internal_reset, 1'b1);
    check("rst_src", 32'(selected_source), 32'(SRC_RC_CAL));
    rst <= 1'b0;
    for (int i = 0; i < 16; i++)
      run_start(4'(i), 2'($urandom_range(0, 3)), 1'($urandom_range(0, 1)), 1'b0, 1'b0);
    for (int i = 0; i < 7; i++)
      run_start(ts[i], tu[i], 1'b0, 1'(i == 1), 1'b1);
    // shipped fuses: 8 MHz rc divided by eight
    count_pulses(64, c, p, v, f);
    check("div8_rate", c, 8);
    apb_xfer(1'b0, `OFF_STATUS, 32'h0, rd, er);
    check("phase_run", rd[2:0], 3'h3);
    apb_xfer(1'b0, 8'h10, 32'h0, rd, er);
    check("unmapped_err", er, 1'b1);
    check("unmapped_data", rd, 32'h0);
    clock_source_select <= 4'hF;
    repeat (4) @(posedge clk_sys);
    check("fuse_frozen", 32'(selected_source), 32'(SRC_RC_CAL));
    clock_source_select <= 4'h2;
    for (int i = 0; i < 4; i++)
    begin
      psc = (i == 0) ? 9 : (i == 3) ? 0 : $urandom_range(1, 7);
      apb_xfer(1'b1, `OFF_PRESCALE, 32'(psc), rd, er);
      per = 1 << ((psc > 8) ? 8 : psc);
      repeat (260) @(posedge clk_sys);
      count_pulses(4 * per, c, p, v, f);
      check("core_rate", c, 4);
      check("per_rate", p, 4);
      check("conv_rate", v, 4);
      check("flash_follow", f, 0);
    end
    sleep_wake(SL_CONV, 1'b1, 1'b0, 0, 4, 1'b1);
    sleep_wake(SL_PDOWN, 1'b1, 1'b0, 4, 16, 1'b0);
    sleep_wake(SL_PDOWN, 1'b0, 1'b0, 4, 16, 1'b0);
    sleep_wake(SL_PSAVE, 1'b1, 1'b1, 10, 26, 1'b1);
    // second reset in mid-run must restart the whole sequence
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("rerst_hold", internal_reset, 1'b1);
    check("rerst_core", core_clock_en, 1'b0);
    rst <= 1'b0;
    run_start(4'h2, 2'h2, 1'b0, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule
`default_nettype wire
